// *** sfrmap_bank.sv ***
// special-function register bank with crystal pin options
`timescale 1ns/1ps
`default_nettype none
module sfrmap_bank (
	input wire logic core_clk, // cpu clock
	input wire logic rst, // sync reset, active high
	input wire logic [7:0] sfrAddr, // sfr address
	input wire logic [7:0] sfrWdata, // write data
	input wire logic sfrWr, // byte write strobe
	input wire logic sfrRd, // read strobe
	output logic [7:0] sfrRdata, // read data, registered
	input wire logic bitWr, // bit write strobe
	input wire logic [7:0] bitAddr, // bit address
	input wire logic bitVal, // bit write value
	output logic bitRdata, // addressed bit value, combinational
	input wire logic [2:0] clkSource, // nonvolatile clock option
	input wire logic rtcOnCrystal, // crystal pins clock the system timer
	input wire logic cmp1Raw, // comparator one analog result, async
	input wire logic cmp2Raw, // comparator two analog result, async
	input wire logic eeDoneEvt, // eeprom done pulse, core clock
	input wire logic eeHvErrEvt, // high-voltage error pulse, core clock
	input wire logic port3Bit0Out, // port bit 0 value
	input wire logic port3Bit0Oe, // port bit 0 enable
	input wire logic port3Bit1Out, // port bit 1 value
	input wire logic port3Bit1Oe, // port bit 1 enable
	output logic [7:0] auxReg, // auxiliary function
	output logic [7:0] cmp1Ctrl, // comparator one control
	output logic [7:0] cmp2Ctrl, // comparator two control
	output logic [7:0] brgCtrl, // baud generator control
	output logic [15:0] baudRate, // baud divisor
	output logic [7:0] accReg, // accumulator
	output logic [7:0] bReg, // b operand
	output logic [31:0] ccCtrl, // capture compare a..d controls
	output logic [7:0] eeCtrl, // eeprom control
	output logic [7:0] trimReg, // trim register
	output logic crystalMode, // pins belong to the oscillator
	output logic port3Bit1IsGpio, // bit 1 is a port bit
	output logic halfRateClockOut, // divided clock
	output logic pin0Out, // pin bit 0 value
	output logic pin0Oe, // pin bit 0 enable
	output logic pin1Out, // pin bit 1 value
	output logic pin1Oe // pin bit 1 enable
);
	typedef struct packed {
		logic [7:0] aux;
		logic [7:0] comparator_one_control;
		logic [7:0] comparator_two_control;
		logic [7:0] brg;
		logic [7:0] brlo;
		logic [7:0] brhi;
		logic [7:0] acc;
		logic [7:0] cca;
		logic [7:0] ccb;
		logic [7:0] ccc;
		logic [7:0] ccd;
		logic [7:0] b;
		logic [7:0] dee;
		logic [7:0] trim;
		logic [7:0] rdata;
		logic [1:0] c1Sync;
		logic [1:0] c2Sync;
	} sfrmap_bank_s;
	sfrmap_bank_s state, next_state;

	////////////////////////////////////////////////////////////////
	// decode helpers

	// mask of implemented bits per address; zero means undefined location; no bit here is fixed at one
	function automatic logic [7:0] implMask(input logic [7:0] a);
		case (a)
			sfrmap_pkg::ADDR_AUX: implMask = sfrmap_pkg::MASK_AUX;
			sfrmap_pkg::ADDR_COMPARATOR_ONE_CONTROL, sfrmap_pkg::ADDR_COMPARATOR_TWO_CONTROL: implMask = sfrmap_pkg::MASK_CMP;
			sfrmap_pkg::ADDR_BAUD_GENERATOR_CONTROL: implMask = sfrmap_pkg::MASK_BAUD_GENERATOR_CONTROL;
			sfrmap_pkg::ADDR_CCC, sfrmap_pkg::ADDR_CCD: implMask = sfrmap_pkg::MASK_CCCD;
			sfrmap_pkg::ADDR_DEE: implMask = sfrmap_pkg::MASK_DEE;
			sfrmap_pkg::ADDR_BRLO, sfrmap_pkg::ADDR_BRHI, sfrmap_pkg::ADDR_ACC, sfrmap_pkg::ADDR_CCA,
			sfrmap_pkg::ADDR_CCB, sfrmap_pkg::ADDR_B, sfrmap_pkg::ADDR_TRIM: implMask = 8'hff;
			default: implMask = 8'h00;
		endcase
	endfunction : implMask

	// raw stored byte at an address
	function automatic logic [7:0] rawByte(input sfrmap_bank_s s, input logic [7:0] a);
		case (a)
			sfrmap_pkg::ADDR_AUX: rawByte = s.aux;
			sfrmap_pkg::ADDR_COMPARATOR_ONE_CONTROL: rawByte = s.comparator_one_control;
			sfrmap_pkg::ADDR_COMPARATOR_TWO_CONTROL: rawByte = s.comparator_two_control;
			sfrmap_pkg::ADDR_BAUD_GENERATOR_CONTROL: rawByte = s.brg;
			sfrmap_pkg::ADDR_BRLO: rawByte = s.brlo;
			sfrmap_pkg::ADDR_BRHI: rawByte = s.brhi;
			sfrmap_pkg::ADDR_ACC: rawByte = s.acc;
			sfrmap_pkg::ADDR_CCA: rawByte = s.cca;
			sfrmap_pkg::ADDR_CCB: rawByte = s.ccb;
			sfrmap_pkg::ADDR_CCC: rawByte = s.ccc;
			sfrmap_pkg::ADDR_CCD: rawByte = s.ccd;
			sfrmap_pkg::ADDR_B: rawByte = s.b;
			sfrmap_pkg::ADDR_DEE: rawByte = s.dee;
			sfrmap_pkg::ADDR_TRIM: rawByte = s.trim;
			default: rawByte = 8'h00;
		endcase
	endfunction : rawByte

	// hardware-owned bits of a comparator: result follows synced input,
	// flag sets on change and the set wins over a same-cycle software clear
	function automatic logic [7:0] cmpUpdate(input logic [7:0] cur, input logic [1:0] sync,
		input logic wr, input logic [7:0] wd);
		logic [7:0] r;
		logic chg;
		r = cur;
		chg = sync[1] != cur[sfrmap_pkg::CMP_RESULT_BIT];
		if (wr)
		begin
			r = (r & ~sfrmap_pkg::MASK_CMP_SW) | (wd & sfrmap_pkg::MASK_CMP_SW);
			r[sfrmap_pkg::CMP_FLAG_BIT] = wd[sfrmap_pkg::CMP_FLAG_BIT];
		end
		r[sfrmap_pkg::CMP_RESULT_BIT] = sync[1];
		if (chg)
			r[sfrmap_pkg::CMP_FLAG_BIT] = 1'b1;
		cmpUpdate = r & sfrmap_pkg::MASK_CMP;
	endfunction : cmpUpdate

	////////////////////////////////////////////////////////////////
	// next-state logic: byte writes, bit writes, synchronisers and event flags
	logic [7:0] wrAddr;
	logic [7:0] wrData;
	logic anyWr;
	logic [7:0] bitByteAddr;
	logic [7:0] cur;
	always_comb
	begin
		next_state = state;
		// bit space: e0..e7 map onto the accumulator only
		bitByteAddr = {bitAddr[7:3], 3'h0};
		cur = rawByte(state, bitByteAddr);
		if (bitWr && bitByteAddr == sfrmap_pkg::ADDR_ACC)
			cur[bitAddr[2:0]] = bitVal;
		anyWr = sfrWr || (bitWr && bitByteAddr == sfrmap_pkg::ADDR_ACC);
		wrAddr = sfrWr ? sfrAddr : bitByteAddr;
		wrData = sfrWr ? sfrWdata : cur;
		// stored value is masked so a write leaves reserved and fixed-zero bits at zero
		if (anyWr)
		begin
			case (wrAddr)
				sfrmap_pkg::ADDR_AUX: next_state.aux = wrData & sfrmap_pkg::MASK_AUX;
				sfrmap_pkg::ADDR_BAUD_GENERATOR_CONTROL: next_state.brg = wrData & sfrmap_pkg::MASK_BAUD_GENERATOR_CONTROL;
				sfrmap_pkg::ADDR_BRLO: next_state.brlo = wrData;
				sfrmap_pkg::ADDR_BRHI: next_state.brhi = wrData;
				sfrmap_pkg::ADDR_ACC: next_state.acc = wrData;
				sfrmap_pkg::ADDR_CCA: next_state.cca = wrData;
				sfrmap_pkg::ADDR_CCB: next_state.ccb = wrData;
				sfrmap_pkg::ADDR_CCC: next_state.ccc = wrData & sfrmap_pkg::MASK_CCCD;
				sfrmap_pkg::ADDR_CCD: next_state.ccd = wrData & sfrmap_pkg::MASK_CCCD;
				sfrmap_pkg::ADDR_B: next_state.b = wrData;
				sfrmap_pkg::ADDR_DEE: next_state.dee = wrData & sfrmap_pkg::MASK_DEE;
				sfrmap_pkg::ADDR_TRIM: next_state.trim = wrData;
				default: ; // undefined or comparator: handled below or dropped
			endcase
		end
		// comparator inputs cross from the analog side through two flops
		next_state.c1Sync = {state.c1Sync[0], cmp1Raw};
		next_state.c2Sync = {state.c2Sync[0], cmp2Raw};
		next_state.comparator_one_control = cmpUpdate(state.comparator_one_control, state.c1Sync, sfrWr && sfrAddr == sfrmap_pkg::ADDR_COMPARATOR_ONE_CONTROL,
			sfrWdata);
		next_state.comparator_two_control = cmpUpdate(state.comparator_two_control, state.c2Sync, sfrWr && sfrAddr == sfrmap_pkg::ADDR_COMPARATOR_TWO_CONTROL,
			sfrWdata);
		// eeprom events set their flags after any software write, so set wins
		if (eeDoneEvt)
			next_state.dee[sfrmap_pkg::DEE_IF_BIT] = 1'b1;
		if (eeHvErrEvt)
			next_state.dee[sfrmap_pkg::DEE_HV_BIT] = 1'b1;
		// read data: unimplemented bits read zero, undefined address reads zero
		if (sfrRd)
			next_state.rdata = rawByte(state, sfrAddr) & implMask(sfrAddr);
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state <= '0;
			state.dee <= sfrmap_pkg::RST_DEE;
			state.trim <= sfrmap_pkg::RST_TRIM;
		end
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign sfrRdata = state.rdata;
	// a function result cannot be bit-selected directly, so the byte gets its own net
	logic [7:0] bitByte;
	assign bitByte = rawByte(state, {bitAddr[7:3], 3'h0});
	assign bitRdata = bitByte[bitAddr[2:0]] & ({bitAddr[7:3], 3'h0} == sfrmap_pkg::ADDR_ACC);
	assign auxReg = state.aux;
	assign cmp1Ctrl = state.comparator_one_control;
	assign cmp2Ctrl = state.comparator_two_control;
	assign brgCtrl = state.brg;
	assign baudRate = {state.brhi, state.brlo};
	assign accReg = state.acc;
	assign bReg = state.b;
	assign ccCtrl = {state.ccd, state.ccc, state.ccb, state.cca};
	assign eeCtrl = state.dee;
	assign trimReg = state.trim;

	// pin function select and clock output
	sfrmap_pins u_pins (
		.core_clk(core_clk),
		.rst(rst),
		.clkSource(clkSource),
		.rtcOnCrystal(rtcOnCrystal),
		.clockOutEnable(state.trim[sfrmap_pkg::TRIM_CLKEN_BIT]),
		.port3Bit0Out(port3Bit0Out),
		.port3Bit0Oe(port3Bit0Oe),
		.port3Bit1Out(port3Bit1Out),
		.port3Bit1Oe(port3Bit1Oe),
		.crystalMode(crystalMode),
		.port3Bit1IsGpio(port3Bit1IsGpio),
		.halfRateClockOut(halfRateClockOut),
		.pin0Out(pin0Out),
		.pin0Oe(pin0Oe),
		.pin1Out(pin1Out),
		.pin1Oe(pin1Oe)
	);

	////////////////////////////////////////////////////////////////
	// checks
	property p_undef_reads_zero;
		@(posedge core_clk) disable iff (rst)
		sfrRd && implMask(sfrAddr) == 8'h00 |=> sfrRdata == 8'h00;
	endproperty
	a_undef_reads_zero: assert property (p_undef_reads_zero) else $error("undefined sfr read nonzero");

	property p_cmp_top_zero;
		@(posedge core_clk) disable iff (rst)
		sfrRd && (sfrAddr == sfrmap_pkg::ADDR_COMPARATOR_ONE_CONTROL || sfrAddr == sfrmap_pkg::ADDR_COMPARATOR_TWO_CONTROL) |=> sfrRdata[7:6] == 2'b00;
	endproperty
	a_cmp_top_zero: assert property (p_cmp_top_zero) else $error("comparator reserved bits set");

	property p_aux_fixed_zero;
		@(posedge core_clk) disable iff (rst)
		sfrRd && sfrAddr == sfrmap_pkg::ADDR_AUX |=> sfrRdata[2] == 1'b0;
	endproperty
	a_aux_fixed_zero: assert property (p_aux_fixed_zero) else $error("fixed zero bit read one");

	property p_cmp_flag_set;
		@(posedge core_clk) disable iff (rst)
		state.c1Sync[1] != cmp1Ctrl[sfrmap_pkg::CMP_RESULT_BIT] |=> cmp1Ctrl[sfrmap_pkg::CMP_FLAG_BIT];
	endproperty
	a_cmp_flag_set: assert property (p_cmp_flag_set) else $error("comparator change flag missed");

	property p_ee_flag_set;
		@(posedge core_clk) disable iff (rst)
		eeDoneEvt |=> eeCtrl[sfrmap_pkg::DEE_IF_BIT] && (!eeCtrl[3] || $past(eeCtrl[3]));
	endproperty
	a_ee_flag_set: assert property (p_ee_flag_set) else $error("eeprom flag lost or reserved set");

	property p_acc_bitwrite;
		@(posedge core_clk) disable iff (rst)
		bitWr && !sfrWr && bitAddr[7:3] == 5'h1c |=> accReg[$past(bitAddr[2:0])] == $past(bitVal);
	endproperty
	a_acc_bitwrite: assert property (p_acc_bitwrite) else $error("accumulator bit write lost");

	property p_brg_reserved;
		@(posedge core_clk) disable iff (rst)
		sfrWr && sfrAddr == sfrmap_pkg::ADDR_BAUD_GENERATOR_CONTROL |=> brgCtrl[7:2] == 6'h00;
	endproperty
	a_brg_reserved: assert property (p_brg_reserved) else $error("reserved bits stored");

	property p_comparator_two_control_flag_set;
		@(posedge core_clk) disable iff (rst)
		state.c2Sync[1] != cmp2Ctrl[sfrmap_pkg::CMP_RESULT_BIT] |=> cmp2Ctrl[sfrmap_pkg::CMP_FLAG_BIT];
	endproperty
	a_comparator_two_control_flag_set: assert property (p_comparator_two_control_flag_set) else $error("comparator two change flag missed");

	// result bits follow the second synchroniser stage one edge later
	property p_cmp_result_follows;
		@(posedge core_clk) disable iff (rst)
		1'b1 |=> cmp1Ctrl[sfrmap_pkg::CMP_RESULT_BIT] == $past(state.c1Sync[1])
			&& cmp2Ctrl[sfrmap_pkg::CMP_RESULT_BIT] == $past(state.c2Sync[1]);
	endproperty
	a_cmp_result_follows: assert property (p_cmp_result_follows) else $error("comparator result stale");

	property p_cmp_reserved_zero;
		@(posedge core_clk) disable iff (rst)
		cmp1Ctrl[7:6] == 2'b00 && cmp2Ctrl[7:6] == 2'b00;
	endproperty
	a_cmp_reserved_zero: assert property (p_cmp_reserved_zero) else $error("comparator top bits hold one");

	property p_ee_hv_set;
		@(posedge core_clk) disable iff (rst)
		eeHvErrEvt |=> eeCtrl[sfrmap_pkg::DEE_HV_BIT];
	endproperty
	a_ee_hv_set: assert property (p_ee_hv_set) else $error("high-voltage error flag lost");

	// first edge out of reset shows the documented reset image
	property p_reset_image;
		@(posedge core_clk) disable iff (rst)
		$fell(rst) |-> eeCtrl == sfrmap_pkg::RST_DEE && accReg == 8'h00
			&& cmp1Ctrl == 8'h00 && cmp2Ctrl == 8'h00;
	endproperty
	a_reset_image: assert property (p_reset_image) else $error("reset image wrong");

	property p_dee_reserved_write;
		@(posedge core_clk) disable iff (rst)
		sfrWr && sfrAddr == sfrmap_pkg::ADDR_DEE |=> !eeCtrl[3];
	endproperty
	a_dee_reserved_write: assert property (p_dee_reserved_write) else $error("eeprom reserved bit kept");

	property p_cccd_reserved;
		@(posedge core_clk) disable iff (rst)
		sfrWr && (sfrAddr == sfrmap_pkg::ADDR_CCC || sfrAddr == sfrmap_pkg::ADDR_CCD)
			|=> ccCtrl[31:27] == 5'h00 && ccCtrl[23:19] == 5'h00;
	endproperty
	a_cccd_reserved: assert property (p_cccd_reserved) else $error("compare reserved bits stored");

	property p_aux_dash_zero;
		@(posedge core_clk) disable iff (rst)
		sfrRd && sfrAddr == sfrmap_pkg::ADDR_AUX |=> sfrRdata[1] == 1'b0;
	endproperty
	a_aux_dash_zero: assert property (p_aux_dash_zero) else $error("reserved aux bit read one");

	property p_acc_bytewrite;
		@(posedge core_clk) disable iff (rst)
		sfrWr && sfrAddr == sfrmap_pkg::ADDR_ACC |=> accReg == $past(sfrWdata);
	endproperty
	a_acc_bytewrite: assert property (p_acc_bytewrite) else $error("accumulator byte write lost");

	// bit space outside the accumulator is not served here
	property p_bit_outside_zero;
		@(posedge core_clk) disable iff (rst)
		bitAddr[7:3] != sfrmap_pkg::ACC_BITBASE |-> !bitRdata;
	endproperty
	a_bit_outside_zero: assert property (p_bit_outside_zero) else $error("bit read outside accumulator");
endmodule : sfrmap_bank
`default_nettype wire

// *** sfrmap_pkg.sv ***
// package: sfr offsets, field positions, reset values and clock-source codes
package sfrmap_pkg;
	localparam logic [7:0] ADDR_AUX = 8'ha2;
	localparam logic [7:0] ADDR_COMPARATOR_ONE_CONTROL = 8'hac;
	localparam logic [7:0] ADDR_COMPARATOR_TWO_CONTROL = 8'had;
	localparam logic [7:0] ADDR_BAUD_GENERATOR_CONTROL = 8'hbd;
	localparam logic [7:0] ADDR_BRLO = 8'hbe;
	localparam logic [7:0] ADDR_BRHI = 8'hbf;
	localparam logic [7:0] ADDR_ACC = 8'he0;
	localparam logic [7:0] ADDR_CCA = 8'hea;
	localparam logic [7:0] ADDR_CCB = 8'heb;
	localparam logic [7:0] ADDR_CCC = 8'hec;
	localparam logic [7:0] ADDR_CCD = 8'hed;
	localparam logic [7:0] ADDR_B = 8'hf0;
	localparam logic [7:0] ADDR_DEE = 8'hf1;
	localparam logic [7:0] ADDR_TRIM = 8'h96;
	localparam logic [4:0] ACC_BITBASE = 5'h1c;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DEE = 8'h08;
	localparam logic [7:0] RST_TRIM = 8'h00;
	localparam logic [7:0] MASK_AUX = 8'hf9;
	localparam logic [7:0] MASK_CMP = 8'h3f;
	localparam logic [7:0] MASK_BAUD_GENERATOR_CONTROL = 8'h03;
	localparam logic [7:0] MASK_CCCD = 8'h07;
	localparam logic [7:0] MASK_DEE = 8'hf7;
	localparam logic [7:0] MASK_CMP_SW = 8'h3c;
	localparam int CMP_FLAG_BIT = 0;
	localparam int CMP_RESULT_BIT = 1;
	localparam int TRIM_CLKEN_BIT = 6;
	localparam int DEE_IF_BIT = 7;
	localparam int DEE_HV_BIT = 6;
	localparam logic [2:0] CFG_XTAL_LO = 3'h0;
	localparam logic [2:0] CFG_XTAL_MED = 3'h1;
	localparam logic [2:0] CFG_XTAL_HI = 3'h2;
	localparam logic [2:0] CFG_RC = 3'h3;
	localparam logic [2:0] CFG_WDOG = 3'h4;
	localparam logic [2:0] CFG_EXT = 3'h7;
endpackage : sfrmap_pkg

// *** sfrmap_pins.sv ***
// crystal-pin function select and half-rate clock output
`timescale 1ns/1ps
`default_nettype none
module sfrmap_pins (
	input wire logic core_clk, // cpu clock
	input wire logic rst, // sync reset, active high
	input wire logic [2:0] clkSource, // nonvolatile clock option
	input wire logic rtcOnCrystal, // crystal pins clock the system timer
	input wire logic clockOutEnable, // trim enable bit
	input wire logic port3Bit0Out, // port logic drive value bit 0
	input wire logic port3Bit0Oe, // port logic enable bit 0
	input wire logic port3Bit1Out, // port logic drive value bit 1
	input wire logic port3Bit1Oe, // port logic enable bit 1
	output logic crystalMode, // pins belong to the oscillator
	output logic port3Bit1IsGpio, // bit 1 usable as a port bit
	output logic halfRateClockOut, // divided clock level
	output logic pin0Out, // pin bit 0 drive value
	output logic pin0Oe, // pin bit 0 enable
	output logic pin1Out, // pin bit 1 drive value
	output logic pin1Oe // pin bit 1 enable
);
	typedef struct packed {
		logic div;
	} sfrmap_pins_s;
	sfrmap_pins_s state, next_state;
	logic clkOutAllowed;

	////////////////////////////////////////////////////////////////
	// source decode
	always_comb
	begin
		crystalMode = (clkSource == sfrmap_pkg::CFG_XTAL_LO) || (clkSource == sfrmap_pkg::CFG_XTAL_MED)
			|| (clkSource == sfrmap_pkg::CFG_XTAL_HI) || rtcOnCrystal;
		port3Bit1IsGpio = ((clkSource == sfrmap_pkg::CFG_RC) || (clkSource == sfrmap_pkg::CFG_WDOG))
			&& !rtcOnCrystal;
		// external clock still uses bit 1 as input, yet bit 0 is free for the clock output
		clkOutAllowed = ((clkSource == sfrmap_pkg::CFG_RC) || (clkSource == sfrmap_pkg::CFG_WDOG)
			|| (clkSource == sfrmap_pkg::CFG_EXT)) && !rtcOnCrystal;
	end

	////////////////////////////////////////////////////////////////
	// toggle divider; held low while disabled so each enable starts clean
	always_comb
	begin
		next_state = state;
		next_state.div = (clockOutEnable && clkOutAllowed) ? !state.div : 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			state <= '0;
		else
			state <= next_state;
	end

	// pin muxing: oscillator owns pins in crystal mode, amplifier drive is analog so oe stays low here
	always_comb
	begin
		halfRateClockOut = state.div;
		if (crystalMode)
		begin
			pin0Out = 1'b0;
			pin0Oe = 1'b0;
		end
		else if (clockOutEnable && clkOutAllowed)
		begin
			pin0Out = state.div;
			pin0Oe = 1'b1;
		end
		else
		begin
			pin0Out = port3Bit0Out;
			pin0Oe = port3Bit0Oe;
		end
		pin1Out = port3Bit1IsGpio ? port3Bit1Out : 1'b0;
		pin1Oe = port3Bit1IsGpio ? port3Bit1Oe : 1'b0;
	end

	// the output must follow the divider when enabled
	property p_half_rate_clock_out_toggles;
		@(posedge core_clk) disable iff (rst)
		(clockOutEnable && clkOutAllowed && !crystalMode) [*2] |-> pin0Out != $past(pin0Out);
	endproperty
	a_half_rate_clock_out_toggles: assert property (p_half_rate_clock_out_toggles) else $error("clock out not toggling");

	property p_half_rate_clock_out_blocked;
		@(posedge core_clk) disable iff (rst)
		rtcOnCrystal |-> !(pin0Oe && pin0Out) ##1 1'b1;
	endproperty
	a_half_rate_clock_out_blocked: assert property (p_half_rate_clock_out_blocked) else $error("clock out while rtc on crystal");

	property p_crystal_owns;
		@(posedge core_clk) disable iff (rst)
		crystalMode |-> !pin0Oe && !pin1Oe;
	endproperty
	a_crystal_owns: assert property (p_crystal_owns) else $error("port drives crystal pins");

	property p_gpio1;
		@(posedge core_clk) disable iff (rst)
		!port3Bit1IsGpio |-> !pin1Oe;
	endproperty
	a_gpio1: assert property (p_gpio1) else $error("bit 1 driven while not a port bit");
endmodule : sfrmap_pins
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the sfr bank and crystal pin options
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk, rst, sfrWr, sfrRd, bitWr, bitVal, rtcOnCrystal, cmp1Raw, cmp2Raw, eeDoneEvt, eeHvErrEvt;
	logic port3Bit0Out, port3Bit0Oe, port3Bit1Out, port3Bit1Oe, bitRdata, crystalMode, port3Bit1IsGpio;
	logic halfRateClockOut, pin0Out, pin0Oe, pin1Out, pin1Oe;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata, bitAddr, auxReg, cmp1Ctrl, cmp2Ctrl, brgCtrl, accReg, bReg, eeCtrl;
	logic [7:0] trimReg, rv;
	logic [2:0] clkSource;
	logic [15:0] baudRate;
	logic [31:0] ccCtrl;
	int miscompares, numChecks, seedDummy;
	logic [7:0] mdl [256];
	logic [7:0] addrList [13] = '{8'ha2, 8'hac, 8'had, 8'hbd, 8'hbe, 8'hbf, 8'he0, 8'hea, 8'heb, 8'hec, 8'hed,
		8'hf0, 8'hf1};
	logic [2:0] srcList [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	////////////////////////////////////////////////////////////////////////////////
	// device under test, every input driven from the bench
	sfrmap_bank u_dut (.core_clk(core_clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrWr(sfrWr),
		.sfrRd(sfrRd), .sfrRdata(sfrRdata), .bitWr(bitWr), .bitAddr(bitAddr), .bitVal(bitVal),
		.bitRdata(bitRdata), .clkSource(clkSource), .rtcOnCrystal(rtcOnCrystal), .cmp1Raw(cmp1Raw),
		.cmp2Raw(cmp2Raw), .eeDoneEvt(eeDoneEvt), .eeHvErrEvt(eeHvErrEvt), .port3Bit0Out(port3Bit0Out),
		.port3Bit0Oe(port3Bit0Oe), .port3Bit1Out(port3Bit1Out), .port3Bit1Oe(port3Bit1Oe), .auxReg(auxReg),
		.cmp1Ctrl(cmp1Ctrl), .cmp2Ctrl(cmp2Ctrl), .brgCtrl(brgCtrl), .baudRate(baudRate), .accReg(accReg),
		.bReg(bReg), .ccCtrl(ccCtrl), .eeCtrl(eeCtrl), .trimReg(trimReg), .crystalMode(crystalMode),
		.port3Bit1IsGpio(port3Bit1IsGpio), .halfRateClockOut(halfRateClockOut), .pin0Out(pin0Out),
		.pin0Oe(pin0Oe), .pin1Out(pin1Out), .pin1Oe(pin1Oe));
	////////////////////////////////////////////////////////////////////////////////
	// 100 mhz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// comparison, verdict and bus helpers
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic reportAndStop();
		if (miscompares == 0 && numChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : reportAndStop
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfrAddr = a;
		sfrWdata = d;
		sfrWr = 1'b1;
		@(negedge core_clk);
		sfrWr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		sfrAddr = a;
		sfrRd = 1'b1;
		@(negedge core_clk);
		sfrRd = 1'b0;
		d = sfrRdata;
	endtask : rd
	// reference image of a byte write; masks keep reserved and fixed bits at zero
	function automatic logic [7:0] nextVal(input logic [7:0] a, input logic [7:0] o, input logic [7:0] d);
		case (a)
			8'ha2: return d & 8'hf9;
			8'hac, 8'had: return (d & 8'h3d) | (o & 8'h02);
			8'hbd: return d & 8'h03;
			8'hec, 8'hed: return d & 8'h07;
			8'hf1: return d & 8'hf7;
			default: return d;
		endcase
	endfunction : nextVal
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		logic [7:0] d;
		logic en, half_rate_clock_out, gpio1, xtal, prevHalf;
		int n;
		miscompares = 0;
		numChecks = 0;
		rst = 1'b1;
		{sfrWr, sfrRd, bitWr, bitVal, rtcOnCrystal, cmp1Raw, cmp2Raw, eeDoneEvt, eeHvErrEvt} = '0;
		{port3Bit0Out, port3Bit0Oe, port3Bit1Out, port3Bit1Oe} = '0;
		sfrAddr = 8'h00;
		sfrWdata = 8'h00;
		bitAddr = 8'h00;
		clkSource = 3'h3;
		seedDummy = $urandom(32'h8ba61335);
		for (int i = 0; i < 256; i++)
			mdl[i] = 8'h00;
		mdl[8'hf1] = 8'h08;
		repeat (8) @(negedge core_clk);
		rst = 1'b0;
		check("eeprom reset", eeCtrl, 8'h08);
		// reset image of every register except trim; the reserved eeprom bit reads as zero
		foreach (addrList[i])
		begin
			rd(addrList[i], d);
			check("reset read", d, mdl[addrList[i]] & ((addrList[i] == 8'hf1) ? 8'hf7 : 8'hff));
		end
		// random writes keep reserved and fixed bits at zero, then read back
		for (int pass = 0; pass < 3; pass++)
			foreach (addrList[i])
			begin
				d = nextVal(addrList[i], 8'h00, 8'($urandom));
				wr(addrList[i], d);
				mdl[addrList[i]] = nextVal(addrList[i], mdl[addrList[i]], d);
				rd(addrList[i], d);
				check("readback", d, mdl[addrList[i]]);
			end
		check("acc port", accReg, mdl[8'he0]);
		check("baud hi", baudRate[15:8], mdl[8'hbf]);
		check("cc d port", ccCtrl[31:24], mdl[8'hed]);
		// only defined locations are touched; a byte write lands in its own register alone
		for (int i = 0; i < 3; i++)
		begin
			wr(addrList[4 + i], 8'h5a);
			mdl[addrList[4 + i]] = 8'h5a;
			rd(addrList[3 + i], d);
			check("neighbour read", d, mdl[addrList[3 + i]]);
		end
		// accumulator bit addressing e0..e7 and a neighbour outside it
		for (int k = 0; k < 9; k++)
		begin
			@(negedge core_clk);
			bitAddr = 8'he0 + 8'(k);
			bitVal = 1'($urandom);
			bitWr = 1'b1;
			if (k < 8)
				mdl[8'he0][k] = bitVal;
			@(negedge core_clk);
			bitWr = 1'b0;
			check("bit read", {7'h00, bitRdata}, (k < 8) ? {7'h00, bitVal} : 8'h00);
		end
		check("acc after bits", accReg, mdl[8'he0]);
		// comparator result edges set the flag; writing 24 with the flag bit zero clears it
		for (int c = 0; c < 2; c++)
		begin
			@(negedge core_clk);
			if (c == 0)
				cmp1Raw = 1'b1;
			else
				cmp2Raw = 1'b1;
			n = 0;
			// bounded wait covers the two-flop synchroniser
			while (((c == 0) ? cmp1Ctrl[1] : cmp2Ctrl[1]) !== 1'b1 && n < 8)
			begin
				@(negedge core_clk);
				n++;
			end
			if (n == 8)
			begin
				miscompares++;
				reportAndStop();
			end
			mdl[8'hac + 8'(c)] = mdl[8'hac + 8'(c)] | 8'h03;
			rd(8'hac + 8'(c), d);
			check("cmp flag set", d, mdl[8'hac + 8'(c)]);
			wr(8'hac + 8'(c), 8'h24);
			mdl[8'hac + 8'(c)] = 8'h26;
			rd(8'hac + 8'(c), d);
			check("cmp flag clear", d, mdl[8'hac + 8'(c)]);
		end
		// eeprom events latch their flags
		@(negedge core_clk);
		eeDoneEvt = 1'b1;
		@(negedge core_clk);
		eeDoneEvt = 1'b0;
		eeHvErrEvt = 1'b1;
		@(negedge core_clk);
		eeHvErrEvt = 1'b0;
		mdl[8'hf1] = mdl[8'hf1] | 8'hc0;
		rd(8'hf1, d);
		check("eeprom flags", d, mdl[8'hf1]);
		check("eeprom port", eeCtrl, mdl[8'hf1]);
		// pin ownership over every clock source, timer option and enable
		for (int e = 0; e < 2; e++)
			foreach (srcList[s])
				for (int r = 0; r < 2; r++)
				begin
					en = e[0];
					wr(8'h96, en ? 8'h40 : 8'h00);
					check("trim enable", {7'h00, trimReg[6]}, {7'h00, en});
					@(negedge core_clk);
					clkSource = srcList[s];
					rtcOnCrystal = r[0];
					{port3Bit0Out, port3Bit0Oe, port3Bit1Out, port3Bit1Oe} = 4'($urandom);
					repeat (3) @(negedge core_clk);
					xtal = (clkSource <= 3'h2) || rtcOnCrystal;
					half_rate_clock_out = en && !xtal && !rtcOnCrystal;
					gpio1 = (clkSource == 3'h3 || clkSource == 3'h4) && !rtcOnCrystal;
					check("crystal mode", {7'h00, crystalMode}, {7'h00, xtal});
					check("bit1 gpio", {7'h00, port3Bit1IsGpio}, {7'h00, gpio1});
					check("pin1 oe", {7'h00, pin1Oe}, {7'h00, gpio1 & port3Bit1Oe});
					check("pin0 oe", {7'h00, pin0Oe}, {7'h00, half_rate_clock_out | (!xtal & !rtcOnCrystal & port3Bit0Oe)});
					if (gpio1)
						check("pin1 out", {7'h00, pin1Out}, {7'h00, port3Bit1Out});
					if (!xtal && !half_rate_clock_out)
						check("pin0 out", {7'h00, pin0Out}, {7'h00, port3Bit0Out});
					if (half_rate_clock_out)
					begin
						prevHalf = pin0Out;
						@(negedge core_clk);
						check("half clock", {7'h00, pin0Out}, {7'h00, ~prevHalf});
						check("half level", {7'h00, halfRateClockOut}, {7'h00, pin0Out});
					end
				end
		reportAndStop();
	end
endmodule : tb_top
`default_nettype wire
